//--- hw/flash_host_defines.vh
// register map, command codes and timing counts of the flash host controller
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// register byte offsets on the control bus
`define REG_CTRL 6'h00
`define REG_ADDR 6'h04
`define REG_WDATA 6'h08
`define REG_STATUS 6'h0C
`define REG_RDATA 6'h10

// operation codes written to the control register
`define OP_NONE 4'h0
`define OP_READ 4'h1
`define OP_PROG 4'h2
`define OP_SERASE 4'h3
`define OP_ADDSEC 4'h4
`define OP_CERASE 4'h5
`define OP_WAIT 4'h6
`define OP_RESET 4'h7
`define OP_SUSPEND 4'h8
`define OP_RESUME 4'h9

// status register bit positions
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_REFUSED 3
`define ST_WIN_PRE 4
`define ST_WIN_POST 5
`define ST_RDY 6
`define ST_LOCKOUT 7

// status bits on the flash data bus
`define DQ_RUN_TOGGLE 6
`define DQ_TIME_LIMIT 5
`define DQ_ERASE_WINDOW 3

// step kinds and address selects of the command sequencer
`define K_END 2'b00
`define K_WR 2'b01
`define K_RD 2'b10
`define K_POLL 2'b11
`define A_UNLOCK1 2'b00
`define A_UNLOCK2 2'b01
`define A_USER 2'b10
`define A_USER_DATA 2'b11

// unlock addresses and command bytes in word mode
`define UNLOCK1_ADDR 20'h00555
`define UNLOCK2_ADDR 20'h002AA
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_RESET 8'hF0
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30

// pin timing: times in ns, counts in 20 ns clock cycles (least times round up)
`define CLK_PERIOD_NS 20
`define T_SETUP_NS 20
`define T_WR_PULSE_NS 40
`define T_RD_ACCESS_NS 70
`define T_HOLD_NS 20
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYC ((`T_WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC (((`T_RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 2)
`define HOLD_CYC ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/axil_regs_slave.v
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module axil_regs_slave #(
  parameter AW = 6
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // write address and data
  input wire [AW-1:0] s_awaddr_i,
  input wire s_awvalid_i,
  output wire s_awready_o,
  input wire [31:0] s_wdata_i,
  input wire [3:0] s_wstrb_i,
  input wire s_wvalid_i,
  output wire s_wready_o,
  // write response
  output reg [1:0] s_bresp_o,
  output reg s_bvalid_o,
  input wire s_bready_i,
  // read address and data
  input wire [AW-1:0] s_araddr_i,
  input wire s_arvalid_i,
  output wire s_arready_o,
  output reg [31:0] s_rdata_o,
  output reg [1:0] s_rresp_o,
  output reg s_rvalid_o,
  input wire s_rready_i,
  // register file side
  output wire wr_en_o,
  output reg [AW-1:0] wr_addr_o,
  output reg [31:0] wr_data_o,
  output reg [3:0] wr_strb_o,
  input wire wr_err_i,
  output wire [AW-1:0] rd_addr_o,
  output wire rd_en_o,
  input wire [31:0] rd_data_i,
  input wire rd_err_i
);

  reg aw_full_q;
  reg w_full_q;

  // each channel takes one item until the response has been accepted
  assign s_awready_o = !aw_full_q && !s_bvalid_o;
  assign s_wready_o = !w_full_q && !s_bvalid_o;
  assign wr_en_o = aw_full_q && w_full_q && !s_bvalid_o;
  assign s_arready_o = !s_rvalid_o;
  assign rd_en_o = s_arvalid_i && !s_rvalid_o;
  assign rd_addr_o = s_araddr_i;

  // write path: address and data in either order, response after both
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr_o <= {AW{1'b0}};
      wr_data_o <= 32'h00000000;
      wr_strb_o <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= 2'b00;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_full_q <= 1'b1;
        wr_addr_o <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_full_q <= 1'b1;
        wr_data_o <= s_wdata_i;
        wr_strb_o <= s_wstrb_i;
      end
      if (wr_en_o) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= wr_err_i ? 2'b10 : 2'b00;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // read path: data sampled on the address handshake
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h00000000;
      s_rresp_o <= 2'b00;
    end else if (rd_en_o) begin
      s_rvalid_o <= 1'b1;
      s_rdata_o <= rd_err_i ? 32'h00000000 : rd_data_i;
      s_rresp_o <= rd_err_i ? 2'b10 : 2'b00;
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

endmodule // axil_regs_slave

//--- hw/flash_bus_cycle.v
// one asynchronous read or write cycle on the flash strobe pins
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_bus_cycle #(
  parameter AW = 20,
  parameter DW = 16,
  parameter SETUP = `SETUP_CYC,
  parameter WR_PULSE = `WR_CYC,
  parameter RD_PULSE = `RD_CYC,
  parameter HOLD = `HOLD_CYC
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // cycle request
  input wire start_i,
  input wire is_write_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg done_o,
  output reg [DW-1:0] rdata_o,
  // flash pins
  output reg [AW-1:0] flash_addr_o,
  input wire [DW-1:0] flash_dq_i,
  output reg [DW-1:0] flash_dq_o,
  output reg flash_dq_oe_o,
  output reg ce_n_o,
  output reg oe_n_o,
  output reg we_n_o
);

  localparam P_IDLE = 4'b0001;
  localparam P_SETUP = 4'b0010;
  localparam P_PULSE = 4'b0100;
  localparam P_HOLD = 4'b1000;

  reg [3:0] ph_q;
  reg [7:0] cnt_q;
  reg wr_q;
  reg [DW-1:0] dq_m_q;
  reg [DW-1:0] dq_s_q;

  // data pins are asynchronous to us; the read pulse covers this delay
  always @(posedge clk_sys_i) begin
    dq_m_q <= flash_dq_i;
    dq_s_q <= dq_m_q;
  end

  // strobes rest high from reset on, so no write edge appears at power-up
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ph_q <= P_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= {DW{1'b0}};
      flash_addr_o <= {AW{1'b0}};
      flash_dq_o <= {DW{1'b0}};
      flash_dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (ph_q)
        P_IDLE: begin
          if (start_i) begin
            wr_q <= is_write_i;
            flash_addr_o <= addr_i;
            flash_dq_o <= wdata_i;
            flash_dq_oe_o <= is_write_i;
            ce_n_o <= 1'b0;
            cnt_q <= SETUP[7:0];
            ph_q <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (cnt_q <= 8'h01) begin
            // write: chip enable and write enable low, output enable high
            we_n_o <= !wr_q;
            // reads are paced by output enable, chip enable held low
            oe_n_o <= wr_q;
            cnt_q <= wr_q ? WR_PULSE[7:0] : RD_PULSE[7:0];
            ph_q <= P_PULSE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        P_PULSE: begin
          if (cnt_q <= 8'h01) begin
            if (!wr_q) begin
              rdata_o <= dq_s_q;
            end
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_q <= HOLD[7:0];
            ph_q <= P_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        P_HOLD: begin
          if (cnt_q <= 8'h01) begin
            ce_n_o <= 1'b1;
            flash_dq_oe_o <= 1'b0;
            done_o <= 1'b1;
            ph_q <= P_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: ph_q <= P_IDLE;
      endcase
    end
  end

endmodule // flash_bus_cycle

//--- hw/flash_host.v
// host controller issuing command sequences and status polls to a flash
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_host #(
  parameter FAW = 20,
  parameter FDW = 16
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // AXI4-Lite write channels
  input wire [5:0] s_awaddr_i,
  input wire s_awvalid_i,
  output wire s_awready_o,
  input wire [31:0] s_wdata_i,
  input wire [3:0] s_wstrb_i,
  input wire s_wvalid_i,
  output wire s_wready_o,
  output wire [1:0] s_bresp_o,
  output wire s_bvalid_o,
  input wire s_bready_i,
  // AXI4-Lite read channels
  input wire [5:0] s_araddr_i,
  input wire s_arvalid_i,
  output wire s_arready_o,
  output wire [31:0] s_rdata_o,
  output wire [1:0] s_rresp_o,
  output wire s_rvalid_o,
  input wire s_rready_i,
  // flash pins
  output wire [FAW-1:0] flash_addr_o,
  input wire [FDW-1:0] flash_dq_i,
  output wire [FDW-1:0] flash_dq_o,
  output wire flash_dq_oe_o,
  output wire ce_n_o,
  output wire oe_n_o,
  output wire we_n_o,
  input wire ready_busy_n_i,
  // supply monitor, high while below the lockout threshold
  input wire lockout_threshold_i
);

  localparam S_IDLE = 4'b0001;
  localparam S_FETCH = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_DONE = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] op_q;
  reg [2:0] idx_q;
  reg [1:0] poll_q;
  reg [FDW-1:0] prev_q;
  reg [FAW-1:0] addr_q;
  reg [FDW-1:0] wdata_q;
  reg [FDW-1:0] rdata_q;
  reg done_q;
  reg fail_q;
  reg refused_q;
  reg [1:0] win_q;
  reg start_q;
  reg cyc_wr_q;
  reg [FAW-1:0] cyc_addr_q;
  reg [FDW-1:0] cyc_data_q;
  reg rb_m_q;
  reg rb_s_q;
  reg lk_m_q;
  reg lk_s_q;

  wire wr_en;
  wire [5:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [5:0] rd_addr;
  wire cyc_done;
  wire [FDW-1:0] cyc_rdata;
  wire [11:0] step;
  wire [1:0] kind;
  wire [1:0] asel;
  wire toggled;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;

  // one sequencer step: kind, address select and command byte
  function [11:0] step_of;
    input [3:0] op;
    input [2:0] idx;
    begin
      step_of = {`K_END, `A_UNLOCK1, 8'h00};
      case ({op, idx})
        {`OP_READ, 3'd0}: step_of = {`K_RD, `A_USER, 8'h00};
        {`OP_PROG, 3'd0}, {`OP_SERASE, 3'd0}, {`OP_SERASE, 3'd3},
        {`OP_CERASE, 3'd0}, {`OP_CERASE, 3'd3}:
          step_of = {`K_WR, `A_UNLOCK1, `CMD_UNLOCK1};
        {`OP_PROG, 3'd1}, {`OP_SERASE, 3'd1}, {`OP_SERASE, 3'd4},
        {`OP_CERASE, 3'd1}, {`OP_CERASE, 3'd4}:
          step_of = {`K_WR, `A_UNLOCK2, `CMD_UNLOCK2};
        {`OP_PROG, 3'd2}: step_of = {`K_WR, `A_UNLOCK1, `CMD_PROGRAM};
        {`OP_PROG, 3'd3}: step_of = {`K_WR, `A_USER_DATA, 8'h00};
        {`OP_PROG, 3'd4}, {`OP_CERASE, 3'd6}, {`OP_WAIT, 3'd0}:
          step_of = {`K_POLL, `A_USER, 8'h00};
        {`OP_SERASE, 3'd2}, {`OP_CERASE, 3'd2}:
          step_of = {`K_WR, `A_UNLOCK1, `CMD_ERASE_SETUP};
        {`OP_SERASE, 3'd5}, {`OP_ADDSEC, 3'd1}:
          step_of = {`K_WR, `A_USER, `CMD_SECTOR_ERASE};
        {`OP_CERASE, 3'd5}: step_of = {`K_WR, `A_UNLOCK1, `CMD_CHIP_ERASE};
        {`OP_ADDSEC, 3'd0}, {`OP_ADDSEC, 3'd2}:
          step_of = {`K_RD, `A_USER, 8'h00};
        {`OP_RESET, 3'd0}: step_of = {`K_WR, `A_UNLOCK1, `CMD_RESET};
        {`OP_SUSPEND, 3'd0}: step_of = {`K_WR, `A_USER, `CMD_SUSPEND};
        {`OP_RESUME, 3'd0}: step_of = {`K_WR, `A_USER, `CMD_RESUME};
        default: step_of = {`K_END, `A_UNLOCK1, 8'h00};
      endcase
    end
  endfunction

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // command unlocks and command bytes are fixed by the sequence table; data words come from wdata_q
  assign step = step_of(op_q, idx_q);
  assign kind = step[11:10];
  assign asel = step[9:8];
  // two consecutive status reads differ only while an algorithm runs
  assign toggled = prev_q[`DQ_RUN_TOGGLE] != cyc_rdata[`DQ_RUN_TOGGLE];

  // merged register words; only the implemented low bits are kept
  wire [31:0] addr_mrg;
  wire [31:0] wdata_mrg;
  assign addr_mrg = merge({{(32-FAW){1'b0}}, addr_q}, wr_data, wr_strb);
  assign wdata_mrg = merge({{(32-FDW){1'b0}}, wdata_q}, wr_data, wr_strb);

  ////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flip-flops before use
  always @(posedge clk_sys_i) begin
    rb_m_q <= ready_busy_n_i;
    rb_s_q <= rb_m_q;
    lk_m_q <= lockout_threshold_i;
    lk_s_q <= lk_m_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // register read decode
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (rd_addr == `REG_CTRL) begin
      rd_data[3:0] = op_q;
    end else if (rd_addr == `REG_ADDR) begin
      rd_data[FAW-1:0] = addr_q;
    end else if (rd_addr == `REG_WDATA) begin
      rd_data[FDW-1:0] = wdata_q;
    end else if (rd_addr == `REG_STATUS) begin
      rd_data[`ST_BUSY] = !st_q[0];
      rd_data[`ST_DONE] = done_q;
      rd_data[`ST_FAIL] = fail_q;
      rd_data[`ST_REFUSED] = refused_q;
      rd_data[`ST_WIN_PRE] = win_q[1];
      rd_data[`ST_WIN_POST] = win_q[0];
      rd_data[`ST_RDY] = rb_s_q;
      rd_data[`ST_LOCKOUT] = lk_s_q;
    end else if (rd_addr == `REG_RDATA) begin
      rd_data[FDW-1:0] = rdata_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // write decode flags unmapped addresses and REG_RDATA
  always @* begin
    wr_err = 1'b1;
    if (wr_addr == `REG_CTRL || wr_addr == `REG_ADDR) begin
      wr_err = 1'b0;
    end else if (wr_addr == `REG_WDATA || wr_addr == `REG_STATUS) begin
      wr_err = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes and the command sequencer
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_q <= S_IDLE;
      op_q <= `OP_NONE;
      idx_q <= 3'd0;
      poll_q <= 2'd0;
      prev_q <= {FDW{1'b0}};
      addr_q <= {FAW{1'b0}};
      wdata_q <= {FDW{1'b0}};
      rdata_q <= {FDW{1'b0}};
      done_q <= 1'b0;
      fail_q <= 1'b0;
      refused_q <= 1'b0;
      win_q <= 2'b00;
      start_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      cyc_addr_q <= {FAW{1'b0}};
      cyc_data_q <= {FDW{1'b0}};
    end else begin
      start_q <= 1'b0;
      if (wr_en && st_q == S_IDLE) begin
        if (wr_addr == `REG_ADDR) begin
          addr_q <= addr_mrg[FAW-1:0];
        end else if (wr_addr == `REG_WDATA) begin
          wdata_q <= wdata_mrg[FDW-1:0];
        end else if (wr_addr == `REG_CTRL && wr_strb[0]) begin
          // a supply below threshold would drop every write cycle anyway
          if (lk_s_q && wr_data[3:0] != `OP_READ &&
              wr_data[3:0] != `OP_WAIT) begin
            refused_q <= 1'b1;
          end else if (wr_data[3:0] != `OP_NONE) begin
            op_q <= wr_data[3:0];
            idx_q <= 3'd0;
            poll_q <= 2'd0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            refused_q <= 1'b0;
            st_q <= S_FETCH;
          end
        end
      end else if (wr_en && wr_addr == `REG_CTRL) begin
        // orders given while busy are dropped and reported
        refused_q <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
        end
        S_FETCH: begin
          if (kind == `K_END) begin
            st_q <= S_DONE;
          end else begin
            start_q <= 1'b1;
            cyc_wr_q <= (kind == `K_WR);
            if (asel == `A_UNLOCK1) begin
              cyc_addr_q <= `UNLOCK1_ADDR;
            end else if (asel == `A_UNLOCK2) begin
              cyc_addr_q <= `UNLOCK2_ADDR;
            end else begin
              cyc_addr_q <= addr_q;
            end
            cyc_data_q <= (asel == `A_USER_DATA) ? wdata_q :
                          {{(FDW-8){1'b0}}, step[7:0]};
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (cyc_done) begin
            st_q <= S_FETCH;
            if (kind == `K_RD) begin
              rdata_q <= cyc_rdata;
              // window flag sampled around the extra sector cycle
              win_q <= {win_q[0], cyc_rdata[`DQ_ERASE_WINDOW]};
              idx_q <= idx_q + 3'd1;
            end else if (kind == `K_WR) begin
              idx_q <= idx_q + 3'd1;
            end else begin
              rdata_q <= cyc_rdata;
              prev_q <= cyc_rdata;
              if (poll_q == 2'd0 || poll_q == 2'd2) begin
                poll_q <= poll_q + 2'd1;
              end else if (!toggled) begin
                // steady run toggle bit: the algorithm has ended
                poll_q <= 2'd0;
                idx_q <= idx_q + 3'd1;
              end else if (poll_q == 2'd3) begin
                // still toggling after the limit flag: failed operation
                fail_q <= 1'b1;
                op_q <= `OP_RESET;
                idx_q <= 3'd0;
                poll_q <= 2'd0;
              end else if (cyc_rdata[`DQ_TIME_LIMIT]) begin
                // limit flag only counts while the toggle shows busy
                poll_q <= 2'd2;
              end
            end
          end
        end
        S_DONE: begin
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave and pin cycle engine
  axil_regs_slave #(
    .AW(6)
  ) u_slave (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i),
    .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i),
    .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i),
    .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
    .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
    .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
    .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
    .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
    .s_rready_i(s_rready_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_strb_o(wr_strb), .wr_err_i(wr_err),
    .rd_addr_o(rd_addr), .rd_en_o(), .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  flash_bus_cycle #(
    .AW(FAW),
    .DW(FDW)
  ) u_cycle (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_q),
    .is_write_i(cyc_wr_q), .addr_i(cyc_addr_q), .wdata_i(cyc_data_q),
    .done_o(cyc_done), .rdata_o(cyc_rdata), .flash_addr_o(flash_addr_o),
    .flash_dq_i(flash_dq_i), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o)
  );

endmodule // flash_host

//--- verif/flash_host_checker.sv
// pin and register bus assertions for the flash host controller
`timescale 1ns/1ps
module flash_host_checker (
  // clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // register bus answers
  input wire s_bvalid_o,
  input wire s_bready_i,
  input wire [1:0] s_bresp_o,
  input wire s_rvalid_o,
  input wire s_rready_i,
  input wire [31:0] s_rdata_o,
  // flash strobes
  input wire ce_n_o,
  input wire oe_n_o,
  input wire we_n_o,
  input wire flash_dq_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  //////////////////////////////////////////////////////////////////////////
  strobe_excl_a: assert property (oe_n_o || we_n_o)
    else $error("oe and we low");
  write_ce_a: assert property (!we_n_o |-> !ce_n_o && flash_dq_oe_o)
    else $error("write without ce or data");
  wr_setup_a: assert property ($fell(we_n_o) |-> !$past(ce_n_o))
    else $error("no ce setup");
  wr_pulse_a: assert property ($fell(we_n_o) |=> !we_n_o ##1 we_n_o)
    else $error("bad we pulse");
  wr_hold_a: assert property (
    $rose(we_n_o) |-> !ce_n_o && flash_dq_oe_o)
    else $error("no write hold");
  rd_pulse_a: assert property (
    $fell(oe_n_o) |-> !oe_n_o[*6] ##1 oe_n_o)
    else $error("bad oe pulse");
  bresp_hold_a: assert property (s_bvalid_o && !s_bready_i |=>
    s_bvalid_o && $stable(s_bresp_o)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_rvalid_o && !s_rready_i |=>
    s_rvalid_o && $stable(s_rdata_o)) else $error("rdata dropped");
  bvalid_drop_a: assert property (s_bvalid_o && s_bready_i |=> !s_bvalid_o)
    else $error("bvalid held after take");
  rvalid_drop_a: assert property (s_rvalid_o && s_rready_i |=> !s_rvalid_o)
    else $error("rvalid held after take");
  // main scenarios
  cover property ($fell(we_n_o));
  cover property ($fell(oe_n_o));
  cover property (s_bvalid_o && s_bresp_o == 2'b10);
endmodule // flash_host_checker

bind flash_host flash_host_checker chk (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
  .s_bresp_o(s_bresp_o), .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i),
  .s_rdata_o(s_rdata_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
  .we_n_o(we_n_o), .flash_dq_oe_o(flash_dq_oe_o));

//--- verif/flash_dev_model.sv
// behavioural flash device answering the host's strobes
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_dev_model #(
  parameter BUSY_READS = 5
) (
  // flash pins
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic ready_busy_n_o
);
  logic [15:0] arr = 16'hFFFF;
  logic [15:0] wd = 16'h0000;
  logic [1:0] seq = 2'h0;
  logic tog = 1'b0;
  logic fail = 1'b0;
  int left = 0;
  int writes = 0;
  //////////////////////////////////////////////////////////////////////////
  // writes land on we_n rising only with ce_n low and oe_n high
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i) begin
      writes <= writes + 1;
      if (dq_i[7:0] == `CMD_RESET) begin
        left <= 0;
        fail <= 1'b0;
        seq <= 2'h0;
      end else if (left != 0) begin
        seq <= 2'h0;
      end else if (seq == 2'h3) begin
        fail <= |(~arr & dq_i);
        arr <= arr & dq_i;
        wd <= dq_i;
        left <= BUSY_READS;
        seq <= 2'h0;
      end else if (addr_i == `UNLOCK1_ADDR && dq_i[7:0] == `CMD_UNLOCK1)
        seq <= 2'h1;
      else if (seq == 2'h1 && dq_i[7:0] == `CMD_UNLOCK2)
        seq <= 2'h2;
      else if (seq == 2'h2 && dq_i[7:0] == `CMD_PROGRAM)
        seq <= 2'h3;
      else
        seq <= 2'h0;
    end
  end
  // a read ends when one strobe rises with the other still low
  always @(posedge oe_n_i or posedge ce_n_i) begin
    if ((oe_n_i ^ ce_n_i) && left != 0) begin
      tog <= ~tog;
      if (!fail) left <= left - 1;
    end
  end
  // released bus shows the inverse so stale data never looks valid
  assign dq_o = (left != 0) ? {8'h00, ~wd[7], tog, fail, 5'h00} ^
    {16{ce_n_i | oe_n_i}} : arr ^ {16{ce_n_i | oe_n_i}};
  assign ready_busy_n_o = (left == 0);
endmodule // flash_dev_model

//--- verif/flash_host_test.sv
// self-checking bench of the flash host controller
`timescale 1ns/1ps
module flash_host_test;
  logic clk_sys_i, rstn_i, awv, wv, br, arv, rr, lock;
  logic [5:0] aw, ar;
  logic [31:0] wd, v, rdat;
  logic [15:0] dqh, dqd;
  logic [19:0] fa;
  logic ce, oe, we, doe, rb, awr, wrd, bv, arrd, rv;
  logic [1:0] bresp, rresp, rs;
  int failures, cmp_count, base;
  flash_host uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .s_awaddr_i(aw),
    .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF),
    .s_wvalid_i(wv), .s_wready_o(wrd), .s_bresp_o(bresp), .s_bvalid_o(bv),
    .s_bready_i(br), .s_araddr_i(ar), .s_arvalid_i(arv),
    .s_arready_o(arrd), .s_rdata_o(rdat), .s_rresp_o(rresp),
    .s_rvalid_o(rv), .s_rready_i(rr), .flash_addr_o(fa), .flash_dq_i(dqd),
    .flash_dq_o(dqh), .flash_dq_oe_o(doe), .ce_n_o(ce), .oe_n_o(oe),
    .we_n_o(we), .ready_busy_n_i(rb), .lockout_threshold_i(lock));
  flash_dev_model dev (.addr_i(fa), .dq_i(dqh), .dq_o(dqd), .ce_n_i(ce),
    .oe_n_i(oe), .we_n_i(we), .ready_busy_n_o(rb));
  //////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // each channel is dropped at the edge where it is taken
  task wr(input [5:0] a, input [31:0] d, input [1:0] e);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk(bresp, e);
    @(posedge clk_sys_i);
  endtask
  task rd(input [5:0] a);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arrd) arv <= 1'b0;
    end while (!rv);
    v = rdat;
    rs = rresp;
    rr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // poll status until busy clears, giving up after 300 reads
  task idle();
    repeat (300) begin
      rd(6'h0C);
      if (v[0] === 1'b0) return;
    end
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    failures++;
    close_out();
  end
  initial begin
    {awv, wv, br, arv, rr, lock, rstn_i} = 7'h00;
    {aw, ar, wd} = 44'h0;
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    chk({ce, oe, we, doe}, 4'hE);
    rd(6'h0C);
    chk({v[7:6], v[3:0]}, 6'h10);
    wr(6'h14, 32'h0, 2'b10);
    rd(6'h14);
    chk(rs, 2'b10);
    chk(v, 32'h0);
    // program, then a refused order while the controller is still busy
    base = dev.writes;
    wr(6'h04, 32'h00100, 2'b00);
    wr(6'h08, 32'h1234, 2'b00);
    wr(6'h00, 32'h2, 2'b00);
    wr(6'h00, 32'h1, 2'b00);
    rd(6'h0C);
    chk({v[3], v[0]}, 2'b11);
    idle();
    chk({v[6], v[2:0]}, 4'hA);
    chk(dev.writes - base, 4);
    wr(6'h00, 32'h1, 2'b00);
    idle();
    rd(6'h10);
    chk(v[15:0], 16'h1234);
    // a 1 over a 0 must fail and be followed by the reset command
    base = dev.writes;
    wr(6'h08, 32'hFFFF, 2'b00);
    wr(6'h00, 32'h2, 2'b00);
    idle();
    chk(v[2], 1'b1);
    chk(dev.fail, 1'b0);
    chk(dev.writes - base, 5);
    // suspend is a single bus write; a poll-only order writes nothing
    base = dev.writes;
    wr(6'h00, 32'h8, 2'b00);
    idle();
    wr(6'h00, 32'h6, 2'b00);
    idle();
    chk(v[2:0], 3'b010);
    chk(dev.writes - base, 1);
    // supply below threshold: no write may reach the pins
    lock <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    base = dev.writes;
    wr(6'h00, 32'h2, 2'b00);
    repeat (20) @(posedge clk_sys_i);
    rd(6'h0C);
    chk({v[7], v[3], v[0]}, 3'b110);
    chk(dev.writes - base, 0);
    lock <= 1'b0;
    close_out();
  end
endmodule // flash_host_test
